/* logic/cair_map.vh */
/*
  constants for the current-input converter control and readout block:
  measurement timing, configuration field positions, reset value, lane sizes.
  assumes it is included by bare name from the design files.
*/
`ifndef CAIR_MAP_VH
`define CAIR_MAP_VH

// measurement duration in master clock periods, fast and normal mode
`define CAIR_MEAS_FAST 10'd274
`define CAIR_MEAS_NORM 10'd544
// four conversion slots share one measurement
`define CAIR_SLOTS 3'd4
`define CAIR_SLOT_FAST (`CAIR_MEAS_FAST / 10'd4)
`define CAIR_SLOT_NORM (`CAIR_MEAS_NORM / 10'd4)
`define CAIR_LAST_SLOT 2'd3

// configuration register
`define CAIR_CFG_W 16
`define CAIR_CFG_RST 16'h8100
`define CAIR_CFG_MODE_BIT 14
`define CAIR_CFG_FAST_BIT 8
`define CAIR_CFG_LAST_BIT 5'd15

// result lanes: four lanes of four 16-bit words
`define CAIR_WORD_W 16
`define CAIR_LANE_W 64
`define CAIR_LANES 4
`define CAIR_MEM_W 64

`endif

/* logic/cair_sync.v */
/*
  two flip-flop synchroniser for a vector of independent levels.
  assumes each bit is a slow level or a clock sampled for edges only.
*/
`timescale 1ns/1ns

module cair_sync
#(
  parameter W = 3
)
(
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // asynchronous levels in, synchronised levels out
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_sync
);

reg [W-1:0] meta;

always @(posedge i_clk or posedge i_rst)
begin
  if (i_rst)
  begin
    meta <= {W{1'b0}};
    o_sync <= {W{1'b0}};
  end
  else
  begin
    meta <= i_async;
    o_sync <= meta;
  end
end

endmodule

/* logic/cair_result_mem.v */
/*
  result store: four words, one per conversion slot, each holding the
  four converter results of that slot; registered read data.
  assumes one write and one read per cycle, same clock.
*/
`timescale 1ns/1ns
`include "cair_map.vh"

module cair_result_mem
(
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // write port
  input wire i_wr_en,
  input wire [1:0] i_wr_addr,
  input wire [`CAIR_MEM_W-1:0] i_wr_data,
  // read port
  input wire [1:0] i_rd_addr,
  output reg [`CAIR_MEM_W-1:0] o_rd_data
);

reg [`CAIR_MEM_W-1:0] mem [0:3];

always @(posedge i_clk)
begin
  if (i_wr_en)
    mem[i_wr_addr] <= i_wr_data;
end

always @(posedge i_clk or posedge i_rst)
begin
  if (i_rst)
    o_rd_data <= {`CAIR_MEM_W{1'b0}};
  else
    o_rd_data <= mem[i_rd_addr];
end

endmodule

/* logic/cair_top.v */
/*
  digital control and readout of a 16-channel dual-integrator current
  converter: integration side switching, measurement sequencing of four
  shared converters, result store, serial result shift out with ready
  flag and daisy chain, serial configuration load with readback.
  assumes i_clk is the master clock; side select, serial shift clock and
  daisy input come from the host asynchronously; configuration input is
  driven by the host on the master clock.
*/
//
// Overview of operation
// - measurement lasts 274 or 544 master cycles
// - ready goes low when results are loaded
// - ready returns high after first shift-clock fall
// - lanes shift on shift-clock falls, first bit early
// - daisy input sampled on shift-clock rises
// - configuration bits captured on master clock falls
// - readback sends configuration bit 15 first
// - ready changes on master clock falling edge
// - select rise starts side A integration
// - select fall starts side B, converts side A
// - convert four slots, reset, load results, then idle
// - one side converts while other integrates
// - reset input initialises all logic but the result store words
// - every word shifts out MSB first
// - single-lane mode drives other lanes low
// - one 16-bit configuration register
`timescale 1ns/1ns
`include "cair_map.vh"

module cair_top
(
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // integration control from host
  input wire i_integrate_side_select,
  // serial readout from host
  input wire i_serial_shift_clock,
  input wire i_daisy_in,
  // configuration load
  input wire i_cfg_enable,
  input wire i_cfg_in,
  // results of the four shared converters
  input wire [`CAIR_MEM_W-1:0] i_adc_data,
  // serial readout to host
  output reg o_result_ready_n,
  output reg o_result_lane_first,
  output reg o_result_lane_second,
  output reg o_result_lane_third,
  output reg o_result_lane_fourth,
  // analog front-end control
  output reg o_side_a_integrate,
  output reg o_convert_side_a,
  output reg o_adc_start,
  output reg [1:0] o_adc_slot,
  output reg o_cap_reset
);

localparam ST_IDLE = 2'b00;
localparam ST_CONVERT = 2'b01;
localparam ST_RESET = 2'b10;
localparam ST_LOAD = 2'b11;

//////////////////////////////////////////////////////////////////////
// input synchronisers and edge detect

wire [2:0] sync_out;
reg sel_d;
reg sclk_d;
reg daisy_bit;

cair_sync #(.W(3)) u_sync
(
  .i_clk(i_clk),
  .i_rst(i_rst),
  .i_async({i_daisy_in, i_serial_shift_clock, i_integrate_side_select}),
  .o_sync(sync_out)
);

wire sel_s = sync_out[0];
wire sclk_s = sync_out[1];
wire daisy_s = sync_out[2];
wire sel_edge = sel_s ^ sel_d;
wire sclk_rise = sclk_s & ~sclk_d;
wire sclk_fall = ~sclk_s & sclk_d;

always @(posedge i_clk or posedge i_rst)
begin
  if (i_rst)
  begin
    sel_d <= 1'b0;
    sclk_d <= 1'b0;
    daisy_bit <= 1'b0;
  end
  else
  begin
    sel_d <= sel_s;
    sclk_d <= sclk_s;
    if (sclk_rise)
      daisy_bit <= daisy_s;
  end
end

//////////////////////////////////////////////////////////////////////
// configuration register, loaded on master clock falling edges

reg [`CAIR_CFG_W-1:0] cfg;
reg [`CAIR_CFG_W-1:0] cfg_shift;
reg [4:0] cfg_cnt;
reg cfg_done;

always @(negedge i_clk or posedge i_rst)
begin
  if (i_rst)
  begin
    cfg <= `CAIR_CFG_RST;
    cfg_shift <= {`CAIR_CFG_W{1'b0}};
    cfg_cnt <= 5'h00;
    cfg_done <= 1'b0;
  end
  else
  begin
    cfg_done <= 1'b0;
    if (i_cfg_enable)
    begin
      cfg_shift <= {cfg_shift[`CAIR_CFG_W-2:0], i_cfg_in};
      if (cfg_cnt == `CAIR_CFG_LAST_BIT)
      begin
        cfg <= {cfg_shift[`CAIR_CFG_W-2:0], i_cfg_in};
        cfg_cnt <= 5'h00;
        cfg_done <= 1'b1;
      end
      else
        cfg_cnt <= cfg_cnt + 5'h01;
    end
    else
      cfg_cnt <= 5'h00;
  end
end

wire fast = ~cfg[`CAIR_CFG_FAST_BIT];
wire par = cfg[`CAIR_CFG_MODE_BIT];
wire [9:0] meas_len = fast ? `CAIR_MEAS_FAST : `CAIR_MEAS_NORM;
wire [9:0] slot_len = fast ? `CAIR_SLOT_FAST : `CAIR_SLOT_NORM;

//////////////////////////////////////////////////////////////////////
// integration switching and measurement sequence

reg [1:0] state;
reg [9:0] meas_cnt;
reg [9:0] slot_cnt;
reg [2:0] rd_idx;
reg wr_en;
reg [1:0] wr_addr;
reg [`CAIR_MEM_W-1:0] wr_data;
reg load_done;
wire [`CAIR_MEM_W-1:0] rd_data;

always @(posedge i_clk or posedge i_rst)
begin
  if (i_rst)
  begin
    state <= ST_IDLE;
    meas_cnt <= 10'h000;
    slot_cnt <= 10'h000;
    rd_idx <= 3'h0;
    wr_en <= 1'b0;
    wr_addr <= 2'h0;
    wr_data <= {`CAIR_MEM_W{1'b0}};
    load_done <= 1'b0;
    o_side_a_integrate <= 1'b0;
    o_convert_side_a <= 1'b0;
    o_adc_start <= 1'b0;
    o_adc_slot <= 2'h0;
    o_cap_reset <= 1'b0;
  end
  else
  begin
    wr_en <= 1'b0;
    load_done <= 1'b0;
    o_adc_start <= 1'b0;
    if (sel_edge)
    begin
      o_side_a_integrate <= sel_s;
      o_convert_side_a <= ~sel_s;
      o_cap_reset <= 1'b0;
      o_adc_start <= 1'b1;
      o_adc_slot <= 2'h0;
      meas_cnt <= 10'h001;
      slot_cnt <= 10'h000;
      state <= ST_CONVERT;
    end
    else
    begin
      case (state)
        ST_CONVERT:
        begin
          meas_cnt <= meas_cnt + 10'h001;
          if (slot_cnt == slot_len - 10'h001)
          begin
            wr_en <= 1'b1;
            wr_addr <= o_adc_slot;
            wr_data <= i_adc_data;
            slot_cnt <= 10'h000;
            if (o_adc_slot == `CAIR_LAST_SLOT)
            begin
              o_cap_reset <= 1'b1;
              state <= ST_RESET;
            end
            else
            begin
              o_adc_slot <= o_adc_slot + 2'h1;
              o_adc_start <= 1'b1;
            end
          end
          else
            slot_cnt <= slot_cnt + 10'h001;
        end
        ST_RESET:
        begin
          meas_cnt <= meas_cnt + 10'h001;
          if (meas_cnt >= meas_len)
          begin
            o_cap_reset <= 1'b0;
            rd_idx <= 3'h0;
            state <= ST_LOAD;
          end
        end
        ST_LOAD:
        begin
          rd_idx <= rd_idx + 3'h1;
          if (rd_idx == `CAIR_SLOTS)
          begin
            load_done <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end
end

cair_result_mem u_mem
(
  .i_clk(i_clk),
  .i_rst(i_rst),
  .i_wr_en(wr_en),
  .i_wr_addr(wr_addr),
  .i_wr_data(wr_data),
  .i_rd_addr(rd_idx[1:0]),
  .o_rd_data(rd_data)
);

wire load_step = (state == ST_LOAD) && (rd_idx != 3'h0) && !sel_edge;

//////////////////////////////////////////////////////////////////////
// output shift lanes

reg [`CAIR_LANE_W*`CAIR_LANES-1:0] lanes;
wire [`CAIR_LANE_W*`CAIR_LANES-1:0] next_lanes;
wire [`CAIR_LANES-1:0] next_msb;

genvar k;
generate
  for (k = 0; k < `CAIR_LANES; k = k + 1)
  begin : g_lane
    wire [`CAIR_LANE_W-1:0] cur = lanes[k*`CAIR_LANE_W +: `CAIR_LANE_W];
    wire shift_in;
    if (k == `CAIR_LANES - 1)
      assign shift_in = par ? 1'b0 : daisy_bit;
    else if (k == 0)
      assign shift_in = par ? daisy_bit : lanes[(k+2)*`CAIR_LANE_W-1];
    else
      assign shift_in = par ? 1'b0 : lanes[(k+2)*`CAIR_LANE_W-1];
    wire [`CAIR_LANE_W-1:0] cfg_word;
    if (k == 0)
      assign cfg_word = {cfg, {(`CAIR_LANE_W-`CAIR_CFG_W){1'b0}}};
    else
      assign cfg_word = {`CAIR_LANE_W{1'b0}};
    assign next_lanes[k*`CAIR_LANE_W +: `CAIR_LANE_W] =
      cfg_done ? cfg_word :
      load_step ? {cur[`CAIR_LANE_W-`CAIR_WORD_W-1:0],
                   rd_data[k*`CAIR_WORD_W +: `CAIR_WORD_W]} :
      sclk_fall ? {cur[`CAIR_LANE_W-2:0], shift_in} :
      cur;
    if (k == 0)
      assign next_msb[k] = next_lanes[(k+1)*`CAIR_LANE_W-1];
    else
      assign next_msb[k] = par & next_lanes[(k+1)*`CAIR_LANE_W-1];
  end
endgenerate

reg ready_q;

always @(posedge i_clk or posedge i_rst)
begin
  if (i_rst)
  begin
    lanes <= {(`CAIR_LANE_W*`CAIR_LANES){1'b0}};
    ready_q <= 1'b1;
    o_result_lane_first <= 1'b0;
    o_result_lane_second <= 1'b0;
    o_result_lane_third <= 1'b0;
    o_result_lane_fourth <= 1'b0;
  end
  else
  begin
    lanes <= next_lanes;
    o_result_lane_first <= next_msb[0];
    o_result_lane_second <= next_msb[1];
    o_result_lane_third <= next_msb[2];
    o_result_lane_fourth <= next_msb[3];
    if (cfg_done || load_done)
      ready_q <= 1'b0;
    else if (sclk_fall && !ready_q)
      ready_q <= 1'b1;
  end
end

// ready leaves on the master clock falling edge, after the lanes settle
always @(negedge i_clk or posedge i_rst)
begin
  if (i_rst)
    o_result_ready_n <= 1'b1;
  else
    o_result_ready_n <= ready_q;
end

endmodule

/* bench/cair_top_assertions.sv */
/*
  checker: timing relations at the ports of cair_top.
  assumes single-lane output mode throughout, fast or normal timing.
*/
`timescale 1ns/1ns
module cair_top_chk
(
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // watched ports
  input wire i_integrate_side_select,
  input wire i_serial_shift_clock,
  input wire o_result_ready_n,
  input wire o_result_lane_second,
  input wire o_result_lane_third,
  input wire o_result_lane_fourth,
  input wire o_side_a_integrate,
  input wire o_convert_side_a,
  input wire o_adc_start,
  input wire [1:0] o_adc_slot,
  input wire o_cap_reset
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  AST_START_PULSE: assert property (o_adc_start |=> !o_adc_start)
    else $error("start pulse too long");
  AST_SLOT_SPACING: assert property (o_adc_start && o_adc_slot != 2'd3 |->
    ##[68:136] (o_adc_start && o_adc_slot != 2'd0)) else $error("slot spacing");
  AST_SIDE_A_RISE: assert property ($rose(i_integrate_side_select) |->
    ##[2:5] (o_side_a_integrate && o_adc_start && o_adc_slot == 2'd0))
    else $error("side a start");
  AST_SIDE_B_FALL: assert property ($fell(i_integrate_side_select) |->
    ##[2:5] (o_convert_side_a && !o_side_a_integrate && o_adc_start))
    else $error("side b start");
  AST_SIDES_APART: assert property (!(o_side_a_integrate && o_convert_side_a))
    else $error("both sides busy");
  AST_READY_AFTER_SLOTS: assert property (o_adc_start && o_adc_slot == 2'd3 |->
    ##[60:160] !o_result_ready_n) else $error("ready late");
  AST_READY_RELEASE: assert property
    (!o_result_ready_n && $fell(i_serial_shift_clock) |-> ##[2:6] o_result_ready_n)
    else $error("ready not released");
  AST_TDM_LANES_LOW: assert property
    (!(o_result_lane_second || o_result_lane_third || o_result_lane_fourth))
    else $error("unused lane driven");
  AST_RESET_VALUES: assert property ($fell(i_rst) |->
    (o_result_ready_n && !o_side_a_integrate && !o_adc_start)) else $error("reset state");
  AST_CAP_RESET_AFTER_SLOTS: assert property (o_adc_start && o_adc_slot == 2'd3 |->
    ##[68:136] o_cap_reset) else $error("capacitor reset missing");
endmodule

bind cair_top cair_top_chk chk
(
  .i_clk,
  .i_rst,
  .i_integrate_side_select,
  .i_serial_shift_clock,
  .o_result_ready_n,
  .o_result_lane_second,
  .o_result_lane_third,
  .o_result_lane_fourth,
  .o_side_a_integrate,
  .o_convert_side_a,
  .o_adc_start,
  .o_adc_slot,
  .o_cap_reset
);

/* bench/cair_host_model.sv */
/*
  host model: 80 ns shift clock bursts, daisy data, fall counter.
  assumes the bench raises i_run only after ready falls.
*/
`timescale 1ns/1ns
module cair_host_model
(
  // master clock and burst request
  input wire i_clk,
  input wire i_run,
  // serial side
  output reg o_shift_clock,
  output reg o_daisy,
  output reg [9:0] o_falls
);
  reg [2:0] phase;
  initial
  begin
    o_shift_clock = 1'b1;
    o_daisy = 1'b0;
    o_falls = 10'd0;
    phase = 3'd0;
  end
  // idle high between frames, daisy toggles when unused
  always @(negedge i_clk)
  begin
    if (i_run)
    begin
      o_shift_clock <= phase[2];
      if (phase == 3'd0)
        o_falls <= o_falls + 10'd1;
      phase <= phase + 3'd1;
      o_daisy <= 1'b1;
    end
    else
    begin
      o_shift_clock <= 1'b1;
      o_falls <= 10'd0;
      phase <= 3'd0;
      o_daisy <= ~o_daisy;
    end
  end
endmodule

/* bench/tb_top.sv */
/*
  bench: reset, configuration write and readback, two normal measurements
  read out, then fast timing with a short readout.
  assumes cair_top, its checker and cair_host_model are compiled first.
*/
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
  begin \
    samples_checked = samples_checked + 1; \
    if ((got) !== (ex)) \
    begin \
      fail_count = fail_count + 1; \
      $display("ERROR %s expected %h seen %h", nm, ex, got); \
    end \
  end
module tb_top;
  reg i_clk;
  reg i_rst;
  reg side_sel;
  reg cfg_en;
  reg cfg_in;
  reg run;
  reg [63:0] adc;
  wire shift_clk;
  wire daisy;
  wire [9:0] falls;
  wire ready_n;
  wire lane1;
  wire [1:0] slot;
  integer fail_count;
  integer samples_checked;
  integer k;
  cair_top dut
  (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_integrate_side_select(side_sel),
    .i_serial_shift_clock(shift_clk),
    .i_daisy_in(daisy),
    .i_cfg_enable(cfg_en),
    .i_cfg_in(cfg_in),
    .i_adc_data(adc),
    .o_result_ready_n(ready_n),
    .o_result_lane_first(lane1),
    .o_result_lane_second(),
    .o_result_lane_third(),
    .o_result_lane_fourth(),
    .o_side_a_integrate(),
    .o_convert_side_a(),
    .o_adc_start(),
    .o_adc_slot(slot),
    .o_cap_reset()
  );
  cair_host_model host
  (
    .i_clk(i_clk),
    .i_run(run),
    .o_shift_clock(shift_clk),
    .o_daisy(daisy),
    .o_falls(falls)
  );
  function [15:0] word(input integer cv, input [1:0] s);
    word = {8'h9A, 2'b00, cv[1:0], 2'b00, s};
  endfunction
  ////////////////////////////////////////
  always @(negedge i_clk)
    for (k = 0; k < 4; k = k + 1)
      adc[k*16 +: 16] <= word(k, slot);
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task final_report;
    begin
      if (fail_count == 0 && samples_checked > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task readout(input [255:0] want, input integer nbits);
    integer n;
    integer t;
    begin
      `CHK("first bit", want[255], lane1)
      run <= 1'b1;
      for (n = 1; n <= nbits; n = n + 1)
      begin
        t = 0;
        while (falls != n && t < 20)
        begin
          @(posedge i_clk);
          t = t + 1;
        end
        if (t == 20)
        begin
          `CHK("shift wait", 1'b1, 1'b0)
          final_report;
        end
        repeat (4) @(negedge i_clk);
        if (n == 1)
          `CHK("ready release", 1'b1, ready_n)
        if (n < 256)
          `CHK("serial bit", want[255 - n], lane1)
        else if (n == 257)
          `CHK("daisy bit", 1'b1, lane1)
      end
      run <= 1'b0;
    end
  endtask
  task cfg_write(input [15:0] v);
    integer b;
    begin
      for (b = 15; b >= 0; b = b - 1)
      begin
        @(negedge i_clk);
        cfg_en <= 1'b1;
        cfg_in <= v[b];
      end
      @(negedge i_clk);
      cfg_en <= 1'b0;
      #1 `CHK("ready held", 1'b1, ready_n)
      @(negedge i_clk);
      #1 `CHK("ready on fall", 1'b0, ready_n)
      readout({v, 240'h0}, 16);
    end
  endtask
  task measure(input level, input integer nbits, input integer lo);
    integer t;
    integer w;
    reg [255:0] want;
    begin
      for (w = 0; w < 16; w = w + 1)
        want[255 - w*16 -: 16] = word(w / 4, w[1:0]);
      @(negedge i_clk);
      side_sel <= level;
      t = 0;
      while (ready_n !== 1'b0 && t < 700)
      begin
        @(posedge i_clk);
        #1 t = t + 1;
      end
      `CHK("measure time", 1'b1, (t >= lo && t <= lo + 12))
      if (t == 700)
        final_report;
      readout(want, nbits);
    end
  endtask
  initial
  begin
    fail_count = 0;
    samples_checked = 0;
    i_rst = 1'b1;
    side_sel = 1'b0;
    cfg_en = 1'b0;
    cfg_in = 1'b0;
    run = 1'b0;
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
    @(posedge i_clk);
    #1 `CHK("reset ready", 1'b1, ready_n)
    `CHK("reset lane", 1'b0, lane1)
    cfg_write(16'h8125);
    measure(1'b1, 258, 548);
    measure(1'b0, 258, 548);
    cfg_write(16'h8025);
    measure(1'b1, 64, 278);
    final_report;
  end
endmodule
